// >>> src/ssf_defines.svh
`ifndef SSF_DEFINES_SVH
`define SSF_DEFINES_SVH

// register offsets on the device register access port
`define SSF_ADDR_W 8
`define SSF_SEC_STATUS_OFS 8'h00
`define SSF_CONV_STATUS_OFS 8'h01

// field positions
`define SSF_DATA_W 16
`define SSF_SEC_READY_BIT 0
`define SSF_TRIM_FAULT_BIT 5
`define SSF_CONV_FAULT_BIT 15

// reset values
`define SSF_STATUS_RST 16'h0000

// trim memory width watched for changes
`define SSF_TRIM_W 16

// timing
`define SSF_CLK_HZ 20000000
`define SSF_PWM_MAX_HZ 30000
`define SSF_PWM_MIN_CYC ((`SSF_CLK_HZ + `SSF_PWM_MAX_HZ - 1) / `SSF_PWM_MAX_HZ)
`define SSF_PWM_CNT_W 10

`endif

// >>> src/ssf_pkg.sv
package ssf_pkg;

  typedef enum logic [1:0] {
    SSF_MODE_OFF,
    SSF_MODE_CFG1,
    SSF_MODE_CFG2,
    SSF_MODE_ACTIVE
  } ssf_mode_t;

  typedef struct packed {
    logic vref_ov;
    logic vref_uv;
    logic vref_ilim;
    logic xfer_err;
  } ssf_conv_src_t;

  typedef struct packed {
    logic secondary_ready;
    logic secondary_trim_check_fault;
    logic conv_fault;
  } ssf_flags_t;

endpackage

// >>> src/ssf_pwm_rate_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "ssf_defines.svh"

module ssf_pwm_rate_chk (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // control and input
  input wire logic enable_i,
  input wire logic pwm_i,
  // result
  output logic too_fast_o
);

  localparam int unsigned MIN_CYC = `SSF_PWM_MIN_CYC;
  localparam logic [`SSF_PWM_CNT_W-1:0] MIN_CNT =
    MIN_CYC[`SSF_PWM_CNT_W-1:0];

  logic pwm_prev_reg;
  logic seen_edge_reg;
  logic [`SSF_PWM_CNT_W-1:0] gap_reg;
  logic rise;

  assign rise = pwm_i & ~pwm_prev_reg;

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      pwm_prev_reg <= 1'b0;
    end else begin
      pwm_prev_reg <= pwm_i;
    end
  end

  // gap since last rising edge, saturating at the legal period
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i || !enable_i) begin
      gap_reg <= '0;
      seen_edge_reg <= 1'b0;
    end else if (rise) begin
      gap_reg <= {{(`SSF_PWM_CNT_W-1){1'b0}}, 1'b1};
      seen_edge_reg <= 1'b1;
    end else if (gap_reg < MIN_CNT) begin
      gap_reg <= gap_reg + {{(`SSF_PWM_CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // first edge after enable only arms the check
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      too_fast_o <= 1'b0;
    end else begin
      too_fast_o <= enable_i & rise & seen_edge_reg &
                    (gap_reg < MIN_CNT);
    end
  end

endmodule // ssf_pwm_rate_chk

`default_nettype wire

// >>> src/ssf_status_flags.sv
// How it works
// - bit 0 of the secondary word is 1 while that side can operate, reset 0.
// - a change of any stored trim bit sets the trim fault in CFG2 or ACTIVE.
// - reference supply out of range sets the converter fault in bit 15.
// - a transfer error toward the primary side sets the converter fault.
// - PWM edges faster than 30 kHz while enabled set the converter fault.
// - converter faults show only while enabled, else the flag stays 0.
// - reserved bits 14..0 (converter) and 4..1 (secondary) read 0.
`timescale 1ns/1ps
`default_nettype none
`include "ssf_defines.svh"

module ssf_status_flags (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // secondary side state
  input wire logic sec_can_operate_i,
  input wire ssf_pkg::ssf_mode_t mode_i,
  input wire logic [`SSF_TRIM_W-1:0] trim_bits_i,
  // converter
  input wire logic conv_enable_i,
  input wire ssf_pkg::ssf_conv_src_t conv_src_i,
  input wire logic pwm_i,
  // register access port
  input wire logic rd_stb_i,
  input wire logic [`SSF_ADDR_W-1:0] rd_addr_i,
  input wire logic wr_stb_i,
  input wire logic [`SSF_ADDR_W-1:0] wr_addr_i,
  input wire logic [`SSF_DATA_W-1:0] wr_data_i,
  output logic [`SSF_DATA_W-1:0] rd_data_o,
  output logic rd_valid_o,
  output logic wr_ack_o,
  // flag outputs
  output ssf_pkg::ssf_flags_t flags_o
);

  function automatic logic ofs_hit(input logic [`SSF_ADDR_W-1:0] a);
    ofs_hit = (a == `SSF_SEC_STATUS_OFS) || (a == `SSF_CONV_STATUS_OFS);
  endfunction

  logic [`SSF_TRIM_W-1:0] trim_prev_reg;
  logic trim_prev_valid_reg;
  logic sec_ready_reg;
  logic trim_fault_reg;
  logic conv_fault_reg;
  logic pwm_too_fast;
  logic trim_watch;
  logic conv_event;
  logic [`SSF_DATA_W-1:0] sec_word;
  logic [`SSF_DATA_W-1:0] conv_word;
  logic wr_data_unused;

  ssf_pwm_rate_chk u_rate (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .enable_i(conv_enable_i),
    .pwm_i(pwm_i),
    .too_fast_o(pwm_too_fast)
  );

  // status is read-only, write data goes nowhere
  assign wr_data_unused = ^wr_data_i;

  assign trim_watch = (mode_i == ssf_pkg::SSF_MODE_CFG2) ||
                      (mode_i == ssf_pkg::SSF_MODE_ACTIVE);
  assign conv_event = conv_src_i.vref_ov | conv_src_i.vref_uv |
                      conv_src_i.vref_ilim |
                      conv_src_i.xfer_err |
                      pwm_too_fast;

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      sec_ready_reg <= 1'b0;
    end else begin
      sec_ready_reg <= sec_can_operate_i;
    end
  end

  // baseline follows memory always so entering a watched state
  // never flags an old, legitimate reload
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      trim_prev_reg <= '0;
      trim_prev_valid_reg <= 1'b0;
    end else begin
      trim_prev_reg <= trim_bits_i;
      trim_prev_valid_reg <= 1'b1;
    end
  end

  // sticky until reset; no clear exists for this flag
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      trim_fault_reg <= 1'b0;
    end else if (trim_watch && trim_prev_valid_reg &&
                 (trim_bits_i != trim_prev_reg)) begin
      trim_fault_reg <= 1'b1;
    end
  end

  // disable drops the flag, an event with enable high sets it
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      conv_fault_reg <= 1'b0;
    end else if (!conv_enable_i) begin
      conv_fault_reg <= 1'b0;
    end else if (conv_event) begin
      conv_fault_reg <= 1'b1;
    end
  end

  always_comb begin
    sec_word = `SSF_STATUS_RST;
    sec_word[`SSF_SEC_READY_BIT] = sec_ready_reg;
    sec_word[`SSF_TRIM_FAULT_BIT] = trim_fault_reg;
    conv_word = `SSF_STATUS_RST;
    conv_word[`SSF_CONV_FAULT_BIT] = conv_fault_reg;
  end

  // unmapped offsets read as zero
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      rd_data_o <= `SSF_STATUS_RST;
      rd_valid_o <= 1'b0;
    end else begin
      rd_valid_o <= rd_stb_i;
      if (rd_stb_i && ofs_hit(rd_addr_i)) begin
        rd_data_o <= (rd_addr_i == `SSF_SEC_STATUS_OFS) ? sec_word
                                                         : conv_word;
      end else if (rd_stb_i) begin
        rd_data_o <= `SSF_STATUS_RST;
      end
    end
  end

  // writes are acknowledged but touch nothing
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      wr_ack_o <= 1'b0;
    end else begin
      wr_ack_o <= wr_stb_i & (ofs_hit(wr_addr_i) | ~ofs_hit(wr_addr_i) |
                  (wr_data_unused & 1'b0));
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      flags_o <= '0;
    end else begin
      flags_o.secondary_ready <= sec_ready_reg;
      flags_o.secondary_trim_check_fault <= trim_fault_reg;
      flags_o.conv_fault <= conv_fault_reg;
    end
  end

endmodule // ssf_status_flags

`default_nettype wire

// >>> tb/ssf_status_flags_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module ssf_status_flags_monitor (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // watched inputs
  input wire logic sec_can_operate_i,
  input wire ssf_pkg::ssf_mode_t mode_i,
  input wire logic [15:0] trim_bits_i,
  input wire logic conv_enable_i,
  input wire ssf_pkg::ssf_conv_src_t conv_src_i,
  input wire logic rd_stb_i,
  input wire logic [7:0] rd_addr_i,
  input wire logic wr_stb_i,
  // watched outputs
  input wire logic [15:0] rd_data_o,
  input wire logic rd_valid_o,
  input wire logic wr_ack_o,
  input wire ssf_pkg::ssf_flags_t flags_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  // trim change seen while monitoring is on; the baseline is only
  // settled one edge after reset, so that edge is left out
  sequence s_trim;
    $past(rstn_i) &&
      mode_i inside {ssf_pkg::SSF_MODE_CFG2, ssf_pkg::SSF_MODE_ACTIVE} &&
      trim_bits_i != $past(trim_bits_i);
  endsequence
  AST_READY: assert property (
    ##2 flags_o.secondary_ready == $past(sec_can_operate_i, 2))
    else $error("ready flag wrong");
  AST_TRIM_SET: assert property (
    s_trim |-> ##2 flags_o.secondary_trim_check_fault)
    else $error("trim fault missed");
  AST_TRIM_HOLD: assert property (
    flags_o.secondary_trim_check_fault |=>
      flags_o.secondary_trim_check_fault)
    else $error("trim fault lost");
  AST_VREF: assert property (
    conv_enable_i && |conv_src_i[3:1] |-> ##2 flags_o.conv_fault)
    else $error("supply fault missed");
  AST_XFER: assert property (
    conv_enable_i && conv_src_i.xfer_err |-> ##2 flags_o.conv_fault)
    else $error("transfer fault missed");
  AST_CONV_OFF: assert property (
    !conv_enable_i |-> ##2 !flags_o.conv_fault)
    else $error("fault while disabled");
  AST_RSVD: assert property (
    rd_valid_o |-> ($past(rd_addr_i) == 8'h01 ? rd_data_o[14:0] == 15'h0000
                                              : rd_data_o[4:1] == 4'h0))
    else $error("reserved bits set");
  AST_WACK: assert property (
    wr_stb_i |=> wr_ack_o)
    else $error("write not acked");
  AST_WACK_ONLY: assert property (
    !wr_stb_i |=> !wr_ack_o)
    else $error("ack without write");
endmodule // ssf_status_flags_monitor
bind ssf_status_flags ssf_status_flags_monitor u_mon (.*);
`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic ref_clk_i, rstn_i, sec_can_operate_i, conv_enable_i, pwm_i;
  logic rd_stb_i, wr_stb_i, rd_valid_o, wr_ack_o;
  logic [7:0] rd_addr_i, wr_addr_i;
  logic [15:0] trim_bits_i, wr_data_i, rd_data_o;
  ssf_pkg::ssf_mode_t mode_i;
  ssf_pkg::ssf_conv_src_t conv_src_i;
  ssf_pkg::ssf_flags_t flags_o;
  // note: bit 16 marks the converter word, bits 15..0 the expected data
  logic [16:0] exp_q[$];
  logic ack_q[$];
  logic [16:0] note;
  int fail_count, samples_checked, cyc;
  ssf_status_flags dut (.*);
  initial begin
    ref_clk_i = 0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  task nc(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask
  task chk(input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch %0t got %h want %h", $time, s, e);
    end
  endtask
  // expectation noted at request time, compared when the answer shows
  task rd(input logic [7:0] a, input logic [15:0] e);
    rd_stb_i = 1;
    rd_addr_i = a;
    exp_q.push_back({a == 8'h01, e});
    nc(1);
    rd_stb_i = 0;
    nc(3);
  endtask
  task wr(input logic [7:0] a);
    wr_stb_i = 1;
    wr_addr_i = a;
    wr_data_i = 16'hFFFF;
    ack_q.push_back(1'b1);
    nc(1);
    wr_stb_i = 0;
    nc(2);
  endtask
  // rising pwm edges exactly g cycles apart
  task pe(input int g);
    pwm_i = 1;
    nc(1);
    pwm_i = 0;
    nc(g - 1);
  endtask
  task print_verdict();
    // a request that never got its answer is a failure too
    if (exp_q.size() != 0 || ack_q.size() != 0) begin
      fail_count++;
      $display("mismatch %0t unanswered requests", $time);
    end
    $display("checked %0d failed %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // flags_o is loaded at the same edge as read data, from the same flags
  always @(negedge ref_clk_i) begin
    if (rd_valid_o === 1'b1) begin
      note = (exp_q.size() > 0) ? exp_q.pop_front() : 17'h1FFFF;
      chk(rd_data_o, note[15:0]);
      if (note[16]) begin
        chk({15'h0000, flags_o.conv_fault}, {15'h0000, note[15]});
      end else begin
        // flags_o[2:1] holds ready then trim fault
        chk({14'h0000, flags_o[2:1]}, {14'h0000, note[0], note[5]});
      end
    end
    if (wr_ack_o === 1'b1) begin
      chk({15'h0000, ack_q.size() > 0}, 16'h0001);
      if (ack_q.size() > 0) begin
        void'(ack_q.pop_front());
      end
    end
  end
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc > 6000) begin
      fail_count++;
      $display("mismatch %0t timeout", $time);
      print_verdict();
    end
  end
  initial begin
    {rstn_i, sec_can_operate_i, conv_enable_i, pwm_i, rd_stb_i} = '0;
    {wr_stb_i, rd_addr_i, wr_addr_i, trim_bits_i, wr_data_i} = '0;
    conv_src_i = '0;
    mode_i = ssf_pkg::SSF_MODE_OFF;
    void'($urandom(33380));
    nc(20);
    rstn_i = 1;
    rd(8'h00, 16'h0000);
    rd(8'h01, 16'h0000);
    sec_can_operate_i = 1;
    trim_bits_i = 16'($urandom);
    nc(2);
    // changes outside CFG2 and ACTIVE must be absorbed
    mode_i = ssf_pkg::SSF_MODE_CFG1;
    trim_bits_i = ~trim_bits_i;
    nc(3);
    rd(8'h00, 16'h0001);
    mode_i = ssf_pkg::SSF_MODE_CFG2;
    nc(2);
    trim_bits_i = trim_bits_i ^ 16'($urandom | 1);
    nc(2);
    rd(8'h00, 16'h0021);
    wr(8'h00);
    wr(8'h01);
    rd(8'h00, 16'h0021);
    rd(8'h01, 16'h0000);
    mode_i = ssf_pkg::SSF_MODE_ACTIVE;
    sec_can_operate_i = 0;
    nc(3);
    rd(8'h00, 16'h0020);
    for (int i = 0; i < 4; i++) begin
      conv_enable_i = 1;
      conv_src_i = 4'(1 << i);
      nc(1);
      conv_src_i = '0;
      nc(2);
      rd(8'h01, 16'h8000);
      conv_enable_i = 0;
      conv_src_i = 4'(1 << i);
      nc(3);
      rd(8'h01, 16'h0000);
    end
    conv_src_i = '0;
    conv_enable_i = 1;
    nc(2);
    pe(667);
    pe(667);
    pe(667);
    rd(8'h01, 16'h0000);
    pe(666);
    pe(1);
    nc(4);
    rd(8'h01, 16'h8000);
    // mid-run reset must clear both sticky flags
    rstn_i = 0;
    nc(2);
    rstn_i = 1;
    rd(8'h00, 16'h0000);
    rd(8'h01, 16'h0000);
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire
